// *** rtl/drsc_top.sv ***
// Read data synchronizer control core with its register slave.
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`default_nettype none

// Function
// - Non-read: read clock is reference halved
// - Non-read: phase-frequency compare on halved clocks
// - Read mode after 1 or 32 oscillator cycles
// - Read mode: loop reference becomes encoded data
// - Before lock: high track rate, phase-frequency
// - Sixteen preamble pulses drive lock output low
// - Lock switches comparator to phase-only
// - Force low: low rate, oscillator clock, decoder
// - Decoded data aligned to read clock
// - Flag missing clock framed by two clocks
// - Window low: reference back, lock released
// - Read end: high rate, outputs initial
// - Data delayed half the reference period
// - Idle muxes: halved reference, halved oscillator
// - Read mode, no lock: data, halved oscillator
// - Locked: feedback is gated oscillator
module drsc_top #(
  parameter int unsigned GATE_CNT_W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic referenceClockDoubleRate,
  input wire logic oscillatorClockOut,
  input wire logic readWindowEnable,
  input wire logic rawEncodedIn,
  input wire logic loopLockForceN,
  output logic readClockOut,
  output logic lockFoundN,
  output logic compareRef,
  output logic compareFeedback,
  output logic phaseOnlyMode,
  output logic highTrackRate,
  output logic decodedReadData,
  output logic syncDataOut,
  output logic absentClockBitFlag,
  output logic irq,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  typedef struct packed {
    logic refS1;
    logic refS2;
    logic refS3;
    logic oscS1;
    logic oscS2;
    logic oscS3;
    logic dataS1;
    logic dataS2;
    logic dataS3;
    logic rweS1;
    logic rweS2;
    logic forceS1;
    logic forceS2;
    logic refHalf;
    logic oscHalf;
    logic [5:0] dlyCnt;
    logic readMode;
    logic lockInt;
    logic [4:0] pulseCnt;
    logic cellClk;
    logic cellData;
    logic prevData;
    logic lastClk;
    logic lastMissing;
    logic beforeClk;
    logic nrzData;
    logic absentFlag;
    logic syncData;
    logic readClk;
    logic refCmp;
    logic fbCmp;
    logic lowTrack;
    logic [1:0] ctrl;
    logic [2:0] irqStatus;
    logic [2:0] irqEnable;
    logic ack;
    logic [31:0] rdat;
  } drsc_state_t;

  drsc_state_t s_r;
  drsc_state_t s_nxt;

  drsc_gate_if gif ();

  logic refRise;
  logic oscRise;
  logic dataRise;
  logic forced;
  logic cellEnd;
  logic patternHit;
  logic [5:0] delayTarget;
  logic wbReq;
  logic [31:0] statusWord;

  ////////////////////////////////////////////////////////////////////////////////
  // Edge detection on the synchronised pins.

  // Only the second and third stages are compared, never the first.
  assign refRise = s_r.refS2 & ~s_r.refS3;
  assign oscRise = s_r.oscS2 & ~s_r.oscS3;
  assign dataRise = s_r.dataS2 & ~s_r.dataS3;
  assign forced = ~s_r.forceS2;
  assign cellEnd = oscRise & s_r.oscHalf;
  assign delayTarget = s_r.ctrl[drsc_pkg::CTRL_LONG_DELAY_BIT] ? drsc_pkg::DELAY_LONG_CYC
                                                              : drsc_pkg::DELAY_SHORT_CYC;
  // A ones preamble puts pulses in the data slot, a zeros preamble in the clock slot.
  assign patternHit = s_r.ctrl[drsc_pkg::CTRL_ZEROS_PATTERN_BIT] ? (s_r.cellClk & ~s_r.cellData)
                                                                 : (s_r.cellData & ~s_r.cellClk);
  assign wbReq = wb_cyc_i & wb_stb_i & ~s_r.ack;

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[drsc_pkg::STAT_READ_MODE_BIT] = s_r.readMode;
    statusWord[drsc_pkg::STAT_LOCK_BIT] = s_r.lockInt;
    statusWord[drsc_pkg::STAT_FORCED_BIT] = forced;
    statusWord[drsc_pkg::STAT_PHASE_ONLY_BIT] = s_r.lockInt;
    statusWord[drsc_pkg::STAT_HIGH_TRACK_BIT] = ~s_r.lowTrack;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse gating unit.

  assign gif.encPulse = dataRise;
  assign gif.refRise = refRise;
  assign gif.oscRise = oscRise;
  assign gif.lock = s_r.lockInt;

  drsc_pulse_gate #(
    .CNT_W(GATE_CNT_W)
  ) u_gate (
    .mclk(mclk),
    .rst(rst),
    .gif(gif)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    s_nxt = s_r;

    s_nxt.refS1 = referenceClockDoubleRate;
    s_nxt.refS2 = s_r.refS1;
    s_nxt.refS3 = s_r.refS2;
    s_nxt.oscS1 = oscillatorClockOut;
    s_nxt.oscS2 = s_r.oscS1;
    s_nxt.oscS3 = s_r.oscS2;
    s_nxt.dataS1 = rawEncodedIn;
    s_nxt.dataS2 = s_r.dataS1;
    s_nxt.dataS3 = s_r.dataS2;
    s_nxt.rweS1 = readWindowEnable;
    s_nxt.rweS2 = s_r.rweS1;
    s_nxt.forceS1 = loopLockForceN;
    s_nxt.forceS2 = s_r.forceS1;

    // Both halved clocks run at all times so the loop never loses its reference.
    if (refRise) begin
      s_nxt.refHalf = ~s_r.refHalf;
    end
    if (oscRise) begin
      s_nxt.oscHalf = ~s_r.oscHalf;
    end

    // Read mode entry, counted in oscillator cycles after the window opens.
    if (!s_r.rweS2) begin
      s_nxt.dlyCnt = 6'h00;
      s_nxt.readMode = 1'b0;
    end else if (!s_r.readMode && oscRise) begin
      s_nxt.dlyCnt = s_r.dlyCnt + 6'h01;
      if (s_r.dlyCnt + 6'h01 >= delayTarget) begin
        s_nxt.readMode = 1'b1;
      end
    end

    // Slot capture: clock slot while oscHalf is low, data slot while high.
    if (cellEnd) begin
      s_nxt.cellClk = 1'b0;
      s_nxt.cellData = 1'b0;
    end
    if (gif.delayedPulse && s_r.readMode) begin
      if (s_r.oscHalf) begin
        s_nxt.cellData = 1'b1;
      end else begin
        s_nxt.cellClk = 1'b1;
      end
    end

    // Preamble detection runs only before lock, in read mode.
    if (cellEnd && s_r.readMode && !s_r.lockInt) begin
      if (patternHit) begin
        s_nxt.pulseCnt = s_r.pulseCnt + 5'h01;
        if (s_r.pulseCnt + 5'h01 >= drsc_pkg::PREAMBLE_PULSES) begin
          s_nxt.lockInt = 1'b1;
        end
      end else begin
        s_nxt.pulseCnt = 5'h00;
      end
    end

    // Decoder: data slot gives the bit, the clock slot is checked for omissions.
    if (cellEnd && s_r.readMode && forced) begin
      s_nxt.nrzData = s_r.cellData;
      s_nxt.prevData = s_r.cellData;
      s_nxt.absentFlag = s_r.beforeClk & s_r.lastMissing & s_r.cellClk;
      s_nxt.beforeClk = s_r.lastClk;
      s_nxt.lastClk = s_r.cellClk;
      s_nxt.lastMissing = ~s_r.cellClk & ~s_r.prevData & ~s_r.cellData;
    end

    // Synchronised data leaves only while reading.
    s_nxt.syncData = gif.delayedPulse & s_r.readMode;

    // Closing the window puts the lock, decoder and data pulse outputs back to their idle values.
    if (!s_r.rweS2) begin
      s_nxt.lockInt = 1'b0;
      s_nxt.pulseCnt = 5'h00;
      s_nxt.nrzData = 1'b0;
      s_nxt.absentFlag = 1'b0;
      s_nxt.prevData = 1'b0;
      s_nxt.lastClk = 1'b0;
      s_nxt.lastMissing = 1'b0;
      s_nxt.beforeClk = 1'b0;
      s_nxt.cellClk = 1'b0;
      s_nxt.cellData = 1'b0;
      s_nxt.syncData = 1'b0;
    end

    // The rate stays high until forced, and returns high when the window closes.
    s_nxt.lowTrack = forced & s_r.rweS2;

    // Read clock: halved reference until forced, then the halved oscillator.
    // Decoded data changes at the falling read clock, so it is stable at the rising one.
    s_nxt.readClk = s_nxt.lowTrack ? s_nxt.oscHalf : s_nxt.refHalf;

    // Comparator reference and feedback selection.
    s_nxt.refCmp = s_nxt.readMode ? s_r.dataS2 : s_nxt.refHalf;
    if (s_nxt.lockInt) begin
      s_nxt.fbCmp = gif.gatedOsc;
    end else begin
      s_nxt.fbCmp = s_nxt.oscHalf;
    end

    // Bus writes; the clear is applied before events so an event in the same cycle wins.
    s_nxt.ack = wbReq;
    // Writes land on the edge at which the master samples ack, while its request still stands.
    if (s_r.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        drsc_pkg::ADDR_CTRL: begin
          s_nxt.ctrl = wb_dat_i[1:0];
        end
        drsc_pkg::ADDR_IRQ_CLEAR: begin
          s_nxt.irqStatus = s_r.irqStatus & ~wb_dat_i[drsc_pkg::IRQ_W-1:0];
        end
        drsc_pkg::ADDR_IRQ_ENABLE: begin
          s_nxt.irqEnable = wb_dat_i[drsc_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    if (s_nxt.lockInt && !s_r.lockInt) begin
      s_nxt.irqStatus[drsc_pkg::IRQ_LOCK_BIT] = 1'b1;
    end
    if (s_nxt.absentFlag && !s_r.absentFlag) begin
      s_nxt.irqStatus[drsc_pkg::IRQ_ABSENT_CLOCK_BIT] = 1'b1;
    end
    if (s_r.readMode && !s_nxt.readMode) begin
      s_nxt.irqStatus[drsc_pkg::IRQ_READ_END_BIT] = 1'b1;
    end

    // Bus reads; unmapped and write-only offsets read as zero.
    s_nxt.rdat = 32'h0000_0000;
    if (wbReq && !wb_we_i) begin
      case (wb_adr_i)
        drsc_pkg::ADDR_CTRL: begin
          s_nxt.rdat = {30'h0000_0000, s_r.ctrl};
        end
        drsc_pkg::ADDR_STATUS: begin
          s_nxt.rdat = statusWord;
        end
        drsc_pkg::ADDR_IRQ_STATUS: begin
          s_nxt.rdat = {29'h0000_0000, s_r.irqStatus};
        end
        drsc_pkg::ADDR_IRQ_ENABLE: begin
          s_nxt.rdat = {29'h0000_0000, s_r.irqEnable};
        end
        default: begin
          s_nxt.rdat = 32'h0000_0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign readClockOut = s_r.readClk;
  assign lockFoundN = ~s_r.lockInt;
  assign compareRef = s_r.refCmp;
  assign compareFeedback = s_r.fbCmp;
  assign phaseOnlyMode = s_r.lockInt;
  assign highTrackRate = ~s_r.lowTrack;
  assign decodedReadData = s_r.nrzData;
  assign syncDataOut = s_r.syncData;
  assign absentClockBitFlag = s_r.absentFlag;
  assign irq = |(s_r.irqStatus & s_r.irqEnable);
  assign wb_dat_o = s_r.rdat;
  assign wb_ack_o = s_r.ack;

endmodule // drsc_top

`default_nettype wire

// *** rtl/drsc_pkg.sv ***
// Shared constants for the disk read data synchronizer control block.
`default_nettype none

package drsc_pkg;

  // Register byte offsets on the bus.
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h08;
  localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h0C;
  localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h10;

  // Control register fields and reset value.
  localparam int unsigned CTRL_LONG_DELAY_BIT = 0;
  localparam int unsigned CTRL_ZEROS_PATTERN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status register fields.
  localparam int unsigned STAT_READ_MODE_BIT = 0;
  localparam int unsigned STAT_LOCK_BIT = 1;
  localparam int unsigned STAT_FORCED_BIT = 2;
  localparam int unsigned STAT_PHASE_ONLY_BIT = 3;
  localparam int unsigned STAT_HIGH_TRACK_BIT = 4;

  // Interrupt status, clear and enable layout.
  localparam int unsigned IRQ_LOCK_BIT = 0;
  localparam int unsigned IRQ_ABSENT_CLOCK_BIT = 1;
  localparam int unsigned IRQ_READ_END_BIT = 2;
  localparam int unsigned IRQ_W = 3;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // Read mode entry delays in oscillator cycles, and the preamble length in pulses.
  localparam logic [5:0] DELAY_SHORT_CYC = 6'h01;
  localparam logic [5:0] DELAY_LONG_CYC = 6'h20;
  localparam logic [4:0] PREAMBLE_PULSES = 5'h10;

  // System clock.
  localparam int unsigned MCLK_PERIOD_NS = 10;

endpackage : drsc_pkg

`default_nettype wire

// *** rtl/drsc_gate_if.sv ***
// Signals between the control core and the pulse gating unit.
`default_nettype none

interface drsc_gate_if;
  logic encPulse;
  logic refRise;
  logic oscRise;
  logic lock;
  logic delayedPulse;
  logic gatedOsc;

  modport ctrl (
    output encPulse,
    output refRise,
    output oscRise,
    output lock,
    input delayedPulse,
    input gatedOsc
  );

  modport gate (
    input encPulse,
    input refRise,
    input oscRise,
    input lock,
    output delayedPulse,
    output gatedOsc
  );
endinterface : drsc_gate_if

`default_nettype wire

// *** rtl/drsc_pulse_gate.sv ***
// Pulse gating unit: half reference period data delay and oscillator gating.
`default_nettype none

module drsc_pulse_gate #(
  parameter int unsigned CNT_W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  drsc_gate_if.gate gif
);

  typedef struct packed {
    logic [CNT_W-1:0] sinceRef;
    logic [CNT_W-1:0] halfPer;
    logic [CNT_W-1:0] dly;
    logic busy;
    logic delayedPulse;
    logic armed;
    logic gatedOsc;
  } drsc_gate_state_t;

  drsc_gate_state_t s_r;
  drsc_gate_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_nxt = s_r;
    s_nxt.delayedPulse = 1'b0;
    s_nxt.gatedOsc = 1'b0;
    // The delay tracks the measured reference period, so it needs no trimming.
    if (gif.refRise) begin
      s_nxt.sinceRef = {{(CNT_W-1){1'b0}}, 1'b1};
      s_nxt.halfPer = {1'b0, s_r.sinceRef[CNT_W-1:1]};
    end else if (s_r.sinceRef != {CNT_W{1'b1}}) begin
      s_nxt.sinceRef = s_r.sinceRef + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    if (s_r.busy) begin
      if (s_r.dly <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
        s_nxt.busy = 1'b0;
        s_nxt.delayedPulse = 1'b1;
      end else begin
        s_nxt.dly = s_r.dly - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
    if (gif.encPulse) begin
      s_nxt.busy = 1'b1;
      s_nxt.dly = (s_r.halfPer == '0) ? {{(CNT_W-1){1'b0}}, 1'b1} : s_r.halfPer;
    end
    // An oscillator edge passes only after a data pulse was sensed.
    if (gif.lock && gif.oscRise && s_r.armed) begin
      s_nxt.gatedOsc = 1'b1;
      s_nxt.armed = 1'b0;
    end else if (!gif.lock) begin
      s_nxt.armed = 1'b0;
    end
    if (s_nxt.delayedPulse && gif.lock) begin
      s_nxt.armed = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign gif.delayedPulse = s_r.delayedPulse;
  assign gif.gatedOsc = s_r.gatedOsc;

endmodule // drsc_pulse_gate

`default_nettype wire

// *** sim/drsc_top_chk.sv ***
// Port level assertions for the read data synchronizer control block.
`default_nettype none

module drsc_top_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic readWindowEnable,
  input wire logic loopLockForceN,
  input wire logic lockFoundN,
  input wire logic phaseOnlyMode,
  input wire logic highTrackRate,
  input wire logic decodedReadData,
  input wire logic syncDataOut,
  input wire logic absentClockBitFlag,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  chk_ack_single: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge missing or held too long");
  chk_data_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside acknowledge");
  // The window pin sync adds two cycles, so eight idle window cycles leave ample margin.
  chk_idle_state: assert property (!readWindowEnable [*8]
    |-> lockFoundN && !phaseOnlyMode && highTrackRate)
    else $error("idle outputs wrong after window low");
  chk_lock_window: assert property ($fell(lockFoundN) |-> readWindowEnable)
    else $error("lock raised outside read window");
  chk_lock_phase: assert property ($fell(lockFoundN) |-> ##[0:2] phaseOnlyMode)
    else $error("lock did not select phase only compare");
  chk_force_rate: assert property ($rose(loopLockForceN) |-> ##[0:6] highTrackRate)
    else $error("high tracking rate not restored after force");
  chk_decode_forced: assert property ($rose(decodedReadData) |-> !highTrackRate)
    else $error("decoded data while decoder idle");
  chk_flag_decode: assert property ($rose(absentClockBitFlag) |-> !highTrackRate && !lockFoundN)
    else $error("missing clock flag outside decoding");
  chk_release_lock: assert property ($fell(readWindowEnable) |-> ##[0:8] lockFoundN)
    else $error("lock not released after window low");
  chk_read_end: assert property ($fell(readWindowEnable) |-> ##[0:8] (highTrackRate && !decodedReadData))
    else $error("outputs not restored after read end");
  chk_pulse_single: assert property (syncDataOut |=> !syncDataOut)
    else $error("delayed data pulse longer than one cycle");
endmodule : drsc_top_chk

bind drsc_top drsc_top_chk drsc_top_chk_inst (.mclk, .rst, .readWindowEnable, .loopLockForceN, .lockFoundN,
  .phaseOnlyMode, .highTrackRate, .decodedReadData, .syncDataOut, .absentClockBitFlag, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o);

`default_nettype wire

// *** sim/drsc_disk_model.sv ***
// Behavioural disk channel: reference, oscillator and encoded preamble pulses.
`default_nettype none

module drsc_disk_model (
  input wire logic mclk,
  input wire logic run,
  input wire logic [1:0] slotSel,
  input wire logic gap,
  output logic refClk,
  output logic oscClk,
  output logic encData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] refCnt = 3'h0;
  logic [4:0] cellCnt = 5'h0;
  logic gapPend = 1'b0;
  logic gapNow = 1'b0;
  logic encR = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // The oscillator stands still until run, so its halving stays in step with the block's.
  assign refClk = refCnt[2];
  assign oscClk = run & ~cellCnt[3];
  assign encData = encR;

  always @(posedge mclk) begin
    refCnt <= refCnt + 3'h1;
    cellCnt <= run ? cellCnt + 5'h1 : 5'h0;
    gapPend <= gap | (gapPend & (cellCnt != 5'h10));
    if (cellCnt == 5'h10) begin
      gapNow <= gapPend;
    end
    // Ones sit in the data slot, zeros as bare clock pulses; a gap drops one whole cell.
    encR <= run & ~gapNow & ((slotSel[0] & (cellCnt == 5'h02)) | (slotSel[1] & (cellCnt == 5'h12)));
  end
endmodule : drsc_disk_model

`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking testbench for the read data synchronizer control block.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic readWindowEnable = 1'b0;
  logic loopLockForceN = 1'b1;
  logic run = 1'b0;
  logic [1:0] slotSel = 2'h0;
  logic gap = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [4:0] wbAdr = 5'h00;
  logic [31:0] wbDat = 32'h0;
  logic [31:0] wbDatO, rdv;
  logic wbAck, refClk, oscClk, encData, readClockOut, lockFoundN, phaseOnlyMode, highTrackRate;
  logic decodedReadData, syncDataOut, absentClockBitFlag, irq, compareRef, compareFeedback;
  int miscompares = 0;
  int samplesChecked = 0;
  int nClk, nSync, nRef, nFbHi;

  initial begin
    forever #5 mclk = ~mclk;
  end

  drsc_disk_model drsc_disk_model_inst (.mclk(mclk), .run(run), .slotSel(slotSel), .gap(gap), .refClk(refClk),
    .oscClk(oscClk), .encData(encData));

  drsc_top drsc_top_inst (.mclk(mclk), .rst(rst), .referenceClockDoubleRate(refClk), .oscillatorClockOut(oscClk),
    .readWindowEnable(readWindowEnable), .rawEncodedIn(encData), .loopLockForceN(loopLockForceN),
    .readClockOut(readClockOut), .lockFoundN(lockFoundN), .compareRef(compareRef), .compareFeedback(compareFeedback),
    .phaseOnlyMode(phaseOnlyMode), .highTrackRate(highTrackRate), .decodedReadData(decodedReadData),
    .syncDataOut(syncDataOut), .absentClockBitFlag(absentClockBitFlag), .irq(irq), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDat), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic checkEq(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  // Classic cycle: held until ack is sampled high, then released for at least one cycle.
  task automatic wbXfer(input logic we, input logic [4:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDat <= wd;
    @(posedge mclk);
    while (wbAck !== 1'b1 && n < 16) begin
      @(posedge mclk);
      n++;
    end
    checkEq(wbAck, 1'b1);
    rdv = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdChk(input logic [4:0] adr, input logic [31:0] exp);
    wbXfer(1'b0, adr, 32'h0);
    checkEq(rdv, exp);
  endtask

  // Feedback is counted by its high samples, so gated pulses stand apart from the halved oscillator.
  task automatic countEdges(input int cyc);
    logic prev;
    logic prevRef;
    nClk = 0;
    nSync = 0;
    nRef = 0;
    nFbHi = 0;
    prev = readClockOut;
    prevRef = compareRef;
    repeat (cyc) begin
      @(posedge mclk);
      nClk += (readClockOut !== prev);
      nSync += (syncDataOut === 1'b1);
      nRef += (compareRef !== prevRef);
      nFbHi += (compareFeedback === 1'b1);
      prev = readClockOut;
      prevRef = compareRef;
    end
  endtask

  task automatic waitLevel(ref logic s, input logic lvl, input int lim);
    int n;
    n = 0;
    while (s !== lvl && n < lim) begin
      @(posedge mclk);
      n++;
    end
    checkEq(s, lvl);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    run <= 1'b1;
    rdChk(drsc_pkg::ADDR_CTRL, 32'h0);
    rdChk(drsc_pkg::ADDR_STATUS, 32'h10);
    rdChk(5'h14, 32'h0);
    wbXfer(1'b1, drsc_pkg::ADDR_IRQ_ENABLE, 32'h7);
    countEdges(64);
    checkEq(nClk, 8);
    checkEq(nRef, 8);
    checkEq(nFbHi, 32);
    checkEq({lockFoundN, phaseOnlyMode, highTrackRate}, 3'h5);
    // Ones preamble with the long entry delay; the window opens only over preamble.
    wbXfer(1'b1, drsc_pkg::ADDR_CTRL, 32'h1);
    slotSel <= 2'h1;
    repeat (64) @(posedge mclk);
    readWindowEnable <= 1'b1;
    repeat (470) @(posedge mclk);
    rdChk(drsc_pkg::ADDR_STATUS, 32'h10);
    repeat (60) @(posedge mclk);
    rdChk(drsc_pkg::ADDR_STATUS, 32'h11);
    waitLevel(lockFoundN, 1'b0, 800);
    checkEq({phaseOnlyMode, highTrackRate, irq}, 3'h7);
    loopLockForceN <= 1'b0;
    repeat (8) @(posedge mclk);
    checkEq(highTrackRate, 1'b0);
    countEdges(64);
    checkEq(nClk, 4);
    checkEq(nSync, 2);
    checkEq(nRef, 4);
    checkEq(nFbHi, 2);
    repeat (64) @(posedge mclk);
    checkEq({decodedReadData, absentClockBitFlag}, 2'h2);
    // Window drops while force is still held low, as when lock feeds force directly.
    readWindowEnable <= 1'b0;
    repeat (10) @(posedge mclk);
    checkEq({lockFoundN, highTrackRate, phaseOnlyMode, decodedReadData}, 4'hC);
    rdChk(drsc_pkg::ADDR_IRQ_STATUS, 32'h5);
    wbXfer(1'b1, drsc_pkg::ADDR_IRQ_CLEAR, 32'h5);
    rdChk(drsc_pkg::ADDR_IRQ_STATUS, 32'h0);
    checkEq(irq, 1'b0);
    loopLockForceN <= 1'b1;
    // Zeros preamble, short delay, lock interrupt masked, then one missing clock.
    wbXfer(1'b1, drsc_pkg::ADDR_IRQ_ENABLE, 32'h2);
    wbXfer(1'b1, drsc_pkg::ADDR_CTRL, 32'h2);
    slotSel <= 2'h2;
    repeat (64) @(posedge mclk);
    readWindowEnable <= 1'b1;
    repeat (30) @(posedge mclk);
    rdChk(drsc_pkg::ADDR_STATUS, 32'h11);
    countEdges(64);
    checkEq(nRef, 4);
    checkEq(nFbHi, 32);
    waitLevel(lockFoundN, 1'b0, 800);
    checkEq(irq, 1'b0);
    loopLockForceN <= 1'b0;
    repeat (96) @(posedge mclk);
    checkEq({decodedReadData, absentClockBitFlag}, 2'h0);
    gap <= 1'b1;
    @(posedge mclk);
    gap <= 1'b0;
    waitLevel(absentClockBitFlag, 1'b1, 128);
    checkEq(irq, 1'b1);
    rdChk(drsc_pkg::ADDR_IRQ_STATUS, 32'h3);
    readWindowEnable <= 1'b0;
    repeat (10) @(posedge mclk);
    checkEq({absentClockBitFlag, lockFoundN}, 2'h1);
    finalReport();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    finalReport();
  end
endmodule : testbench

`default_nettype wire
